// *** occ_map.vh ***
// occ_map.vh: register map, field positions, reset values and timing for the
// oscillator calibration counter.
// assumes: included by bare name from the top design file only; the synchroniser does not use it.
`ifndef OCC_MAP_VH
`define OCC_MAP_VH

// system offsets of the four calibration registers; they are not word
// aligned, so each is kept as an index and the bus address is four times
// (offset minus base)
`define OCC_BASE_OFS 32'h50001600
`define OCC_SEL_OFS 32'h50001600
`define OCC_WIN_OFS 32'h50001602
`define OCC_RESL_OFS 32'h50001604
`define OCC_RESH_OFS 32'h50001606

// interrupt registers, placed after the calibration group (byte addresses)
`define OCC_IRQ_STAT_ADR 8'h20
`define OCC_IRQ_CLR_ADR 8'h24
`define OCC_IRQ_EN_ADR 8'h28

// source control fields
`define OCC_F_GATE_SEL 3
`define OCC_F_START 2
`define OCC_F_SRC_HI 1
`define OCC_F_SRC_LO 0

// calibrated source codes
`define OCC_SRC_SLOW_RC 2'h0
`define OCC_SRC_FAST_RC 2'h1
`define OCC_SRC_SLOW_XTAL 2'h2
`define OCC_SRC_EXT_RC 2'h3

// reset values
`define OCC_SEL_RST 4'h0
`define OCC_WIN_RST 16'h0000
`define OCC_RES_RST 32'h00000000
`define OCC_IRQ_RST 1'h0

// window ends when the down counter holds this value at a reference edge
`define OCC_WIN_LAST 16'h0001

// system clock divider: the fast counter advances once per OCC_DIV_N cycles
`define OCC_DIV_N 4'h1
`define OCC_DIV_LAST 4'h0

// interrupt status bit: run finished
`define OCC_IRQ_DONE 0

`endif

// *** occ_sync.v ***
// occ_sync.v: two flip-flop synchroniser for a bundle of asynchronous levels.
// assumes: each bit is an independent level; no word coherence across bits.
`timescale 1ns/10ps
module occ_sync #(
    parameter W = 1
) (
    input wire clk_i,          // system clock
    input wire rst_i,          // synchronous reset, active high
    input wire [W-1:0] d_i,    // asynchronous levels
    output reg [W-1:0] q_o     // levels in the clk_i domain
);

    reg [W-1:0] meta_reg;

    // the first stage feeds only the second; nothing else looks at it
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule

// *** occ_top.v ***
// occ_top.v: oscillator calibration counter with a classic Wishbone slave.
// assumes: oscillator and external gate inputs are asynchronous to clk_i and
// run well below half the clk_i rate, so every edge is seen after the
// synchroniser; software polls the start bit or takes the interrupt.
// a start written while a run is busy is dropped, and rewriting the source
// fields mid-run only changes their read-back; each run takes them from its own start write.
//
// How it works
// R1: gate select bit picks reference oscillator (0) or external input (1) as gate.
// R2: source field 0..3 selects slow RC, fast RC, slow crystal, extended RC.
// R3: writing one to the start bit begins a run on the selected source.
// R4: start bit clears itself at completion; result is valid from that edge.
// R5: window length loads a down counter stepped by gate edges; ends at one.
// R6: during the window the divided system clock cycles are counted.
// R7: the 32-bit count is read as low and high 16-bit halves.
// R8: counter clears when a run starts; results hold until next completion.
`timescale 1ns/10ps
`include "occ_map.vh"
module occ_top (
    input wire clk_i,              // system clock, 125 MHz
    input wire rst_i,              // synchronous reset, active high
    input wire wb_cyc_i,           // wishbone cycle
    input wire wb_stb_i,           // wishbone strobe
    input wire wb_we_i,            // wishbone write enable
    input wire [7:0] wb_adr_i,     // wishbone byte address
    input wire [3:0] wb_sel_i,     // wishbone byte lanes
    input wire [31:0] wb_dat_i,    // wishbone write data
    output reg [31:0] wb_dat_o,    // wishbone read data
    output reg wb_ack_o,           // wishbone acknowledge
    input wire slow_rc_oscillator_i,      // slow RC oscillator
    input wire fast_rc_oscillator_i,      // fast RC oscillator
    input wire slow_crystal_oscillator_i, // slow crystal oscillator
    input wire extended_rc_oscillator_i,  // extended RC oscillator
    input wire ext_gate_i,         // external gate input
    output reg irq_o               // level interrupt, enabled status set
);

    // bus addresses of the calibration registers: four times the index,
    // worked out at full width and then cut to the 8-bit bus address
    localparam [31:0] ADR_SEL_W = (`OCC_SEL_OFS - `OCC_BASE_OFS) * 32'h00000004;
    localparam [31:0] ADR_WIN_W = (`OCC_WIN_OFS - `OCC_BASE_OFS) * 32'h00000004;
    localparam [31:0] ADR_RESL_W = (`OCC_RESL_OFS - `OCC_BASE_OFS) * 32'h00000004;
    localparam [31:0] ADR_RESH_W = (`OCC_RESH_OFS - `OCC_BASE_OFS) * 32'h00000004;
    localparam [7:0] ADR_SEL = ADR_SEL_W[7:0];
    localparam [7:0] ADR_WIN = ADR_WIN_W[7:0];
    localparam [7:0] ADR_RESL = ADR_RESL_W[7:0];
    localparam [7:0] ADR_RESH = ADR_RESH_W[7:0];

    // run states: idle until a start is taken, wait for the first gate
    // edge so the window opens on a whole reference period, then count
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_COUNT = 2'h2;

    // registers seen by software
    reg gate_source_select_reg;
    reg [1:0] src_sel_reg;
    reg start_reg;
    reg [15:0] calibration_window_length_reg;
    reg [31:0] calibration_result_reg;
    reg irq_stat_reg;
    reg irq_en_reg;

    // run machinery
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] win_cnt_reg;
    reg [31:0] fast_cycle_counter_reg;
    reg [3:0] div_cnt_reg;
    reg run_src_reg;
    reg [1:0] run_sel_reg;
    reg gate_prev_reg;

    wire [4:0] osc_sync;
    wire bus_req;
    wire wr_req;
    wire rd_req;
    wire start_wr;
    wire div_tick;
    wire done;
    reg gate_lvl;
    reg [31:0] rd_data;

    // bring every oscillator and the external input into clk_i;
    // the bit order here fixes which synchronised bit each source code reads
    occ_sync #(
        .W(5)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({ext_gate_i, extended_rc_oscillator_i, slow_crystal_oscillator_i,
              fast_rc_oscillator_i, slow_rc_oscillator_i}),
        .q_o(osc_sync)
    );

    // one access per ack; the ack term keeps a held request from repeating,
    // so each access has exactly one effect on the registers
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_req = bus_req & wb_we_i;
    assign rd_req = bus_req & ~wb_we_i;

    // start request: a one written into the start bit through the low lane
    assign start_wr = wr_req & (wb_adr_i == ADR_SEL) & wb_sel_i[0] & wb_dat_i[`OCC_F_START]; // R3

    // reference selection, latched at start so a mid-run write cannot
    // swap the gate under a running window
    always @* begin
        if (run_src_reg) begin
            gate_lvl = osc_sync[4]; // R1
        end else begin
            case (run_sel_reg) // R2
                `OCC_SRC_SLOW_RC: gate_lvl = osc_sync[0];
                `OCC_SRC_FAST_RC: gate_lvl = osc_sync[1];
                `OCC_SRC_SLOW_XTAL: gate_lvl = osc_sync[2];
                `OCC_SRC_EXT_RC: gate_lvl = osc_sync[3];
                default: gate_lvl = 1'b0;
            endcase
        end
    end

    // rising edge of the selected gate, taken from the synchronised level
    wire gate_edge;
    assign gate_edge = gate_lvl & ~gate_prev_reg;

    // divided system clock: one tick per OCC_DIV_N cycles;
    // with the divider fixed at one this fires on every cycle
    assign div_tick = (div_cnt_reg == `OCC_DIV_LAST);

    // the window is over when the down counter shows one at a gate edge;
    // a zero length behaves as one, so a run can never hang on the counter
    assign done = (state_reg == ST_COUNT) & gate_edge & (win_cnt_reg <= `OCC_WIN_LAST); // R5

    // run state sequencing; counting starts at the first gate edge so the
    // window covers whole reference periods
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_wr) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (gate_edge) begin
                    state_next = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (done) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // gate edge history. at the start of a run the source may switch under
    // the detector, so the history is forced high for one cycle: the old
    // source's low level must not turn the new source's high level into a
    // false first edge that would open the window mid-period. a high level
    // at reset release only makes an edge in ST_IDLE, where nothing uses it
    always @(posedge clk_i) begin
        if (rst_i) begin
            gate_prev_reg <= 1'b0;
        end else if (start_wr && state_reg == ST_IDLE) begin
            gate_prev_reg <= 1'b1; // R5
        end else begin
            gate_prev_reg <= gate_lvl;
        end
    end

    // latch the source and gate mode for the run
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_src_reg <= 1'b0;
            run_sel_reg <= `OCC_SRC_SLOW_RC;
        end else if (start_wr && state_reg == ST_IDLE) begin
            run_src_reg <= wb_dat_i[`OCC_F_GATE_SEL]; // R1
            run_sel_reg <= wb_dat_i[`OCC_F_SRC_HI:`OCC_F_SRC_LO]; // R3
        end
    end

    // window down counter, loaded at start, stepped by gate edges;
    // stepping stops once done is seen, so it is left at its last value
    always @(posedge clk_i) begin
        if (rst_i) begin
            win_cnt_reg <= `OCC_WIN_RST;
        end else if (start_wr && state_reg == ST_IDLE) begin
            win_cnt_reg <= calibration_window_length_reg; // R5
        end else if (state_reg == ST_COUNT && gate_edge && !done) begin
            win_cnt_reg <= win_cnt_reg - 16'h0001; // R5
        end
    end

    // clock divider, restarted with every run so the count is repeatable;
    // it stays so a slower count needs only a change of one constant
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_reg <= `OCC_DIV_LAST;
        end else if (state_reg != ST_COUNT) begin
            div_cnt_reg <= `OCC_DIV_LAST;
        end else if (div_tick) begin
            div_cnt_reg <= `OCC_DIV_N - 4'h1;
        end else begin
            div_cnt_reg <= div_cnt_reg - 4'h1;
        end
    end

    // fast cycle counter: cleared at start, counts ticks inside the window;
    // it wraps silently, so keep windows short enough for 32 bits
    always @(posedge clk_i) begin
        if (rst_i) begin
            fast_cycle_counter_reg <= `OCC_RES_RST;
        end else if (start_wr && state_reg == ST_IDLE) begin
            fast_cycle_counter_reg <= `OCC_RES_RST; // R8
        end else if (state_reg == ST_COUNT && div_tick) begin
            fast_cycle_counter_reg <= fast_cycle_counter_reg + 32'h00000001; // R6
        end
    end

    // result capture: the final tick of the window is included, and the
    // result lands on the same edge that clears the start bit
    always @(posedge clk_i) begin
        if (rst_i) begin
            calibration_result_reg <= `OCC_RES_RST;
        end else if (done) begin
            if (div_tick) begin
                calibration_result_reg <= fast_cycle_counter_reg + 32'h00000001; // R4
            end else begin
                calibration_result_reg <= fast_cycle_counter_reg; // R4
            end
        end
    end

    // start bit: set by a write of one, cleared by hardware at completion.
    // a write of zero does not abort; a write of one while busy is ignored
    always @(posedge clk_i) begin
        if (rst_i) begin
            start_reg <= 1'b0;
        end else if (done) begin
            start_reg <= 1'b0; // R4
        end else if (start_wr) begin
            start_reg <= 1'b1; // R3
        end
    end

    // control fields that software owns; the start bit is not kept here,
    // it has its own process because hardware clears it
    always @(posedge clk_i) begin
        if (rst_i) begin
            gate_source_select_reg <= 1'b0;
            src_sel_reg <= `OCC_SRC_SLOW_RC;
        end else if (wr_req && wb_adr_i == ADR_SEL && wb_sel_i[0]) begin
            gate_source_select_reg <= wb_dat_i[`OCC_F_GATE_SEL];
            src_sel_reg <= wb_dat_i[`OCC_F_SRC_HI:`OCC_F_SRC_LO];
        end
    end

    // window length, byte lanes honoured; a run loads the value at start,
    // so a write during a run applies to the next one
    always @(posedge clk_i) begin
        if (rst_i) begin
            calibration_window_length_reg <= `OCC_WIN_RST;
        end else if (wr_req && wb_adr_i == ADR_WIN) begin
            if (wb_sel_i[0]) begin
                calibration_window_length_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                calibration_window_length_reg[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // interrupt status: completion sets, write-one clears, set wins;
    // a clear that meets a completion in the same cycle loses, so no event is missed
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= `OCC_IRQ_RST;
        end else if (done) begin
            irq_stat_reg <= 1'b1;
        end else if (wr_req && wb_adr_i == `OCC_IRQ_CLR_ADR && wb_sel_i[0] &&
                     wb_dat_i[`OCC_IRQ_DONE]) begin
            irq_stat_reg <= 1'b0;
        end
    end

    // interrupt enable
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_reg <= `OCC_IRQ_RST;
        end else if (wr_req && wb_adr_i == `OCC_IRQ_EN_ADR && wb_sel_i[0]) begin
            irq_en_reg <= wb_dat_i[`OCC_IRQ_DONE];
        end
    end

    // interrupt output registered, one cycle behind status and enable
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_stat_reg & irq_en_reg;
        end
    end

    // read mux; unmapped and write-only addresses read as zero.
    // map, byte addresses on the bus:
    //   0x00 source control: [3] gate select, [2] start/busy, [1:0] source
    //   0x08 window length in reference periods
    //   0x10 / 0x18 low / high half of the last captured count
    //   0x20 interrupt status, 0x24 clear (write one), 0x28 enable
    // both result halves come from one capture that only moves at the end
    // of a run, so they may be read in either order between runs
    always @* begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            ADR_SEL: rd_data = {28'h0000000, gate_source_select_reg, start_reg, src_sel_reg};
            ADR_WIN: rd_data = {16'h0000, calibration_window_length_reg};
            ADR_RESL: rd_data = {16'h0000, calibration_result_reg[15:0]}; // R7
            ADR_RESH: rd_data = {16'h0000, calibration_result_reg[31:16]}; // R7
            `OCC_IRQ_STAT_ADR: rd_data = {31'h00000000, irq_stat_reg};
            `OCC_IRQ_EN_ADR: rd_data = {31'h00000000, irq_en_reg};
            default: rd_data = 32'h00000000;
        endcase
    end

    // single-wait-state answer: every access, mapped or not, is acked
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_req) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule

// *** occ_top_assertions.sv ***
// occ_top_assertions.sv: port-level checks for the calibration counter.
// assumes: bound to occ_top; one classic wishbone master.
`timescale 1ns/10ps
module occ_top_assertions (
    input wire clk_i, // system clock
    input wire rst_i, // synchronous reset
    input wire wb_cyc_i, // cycle
    input wire wb_stb_i, // strobe
    input wire wb_we_i, // write enable
    input wire [7:0] wb_adr_i, // byte address
    input wire [3:0] wb_sel_i, // byte lanes
    input wire [31:0] wb_dat_i, // write data
    input wire [31:0] wb_dat_o, // read data
    input wire wb_ack_o, // acknowledge
    input wire slow_rc_oscillator_i, // reference 0
    input wire fast_rc_oscillator_i, // reference 1
    input wire slow_crystal_oscillator_i, // reference 2
    input wire extended_rc_oscillator_i, // reference 3
    input wire ext_gate_i, // external gate
    input wire irq_o // interrupt
);
    // request taken at this edge; clear register reads 0 so counts as unmapped
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd = req && !wb_we_i;
    wire mapped = wb_adr_i == 8'h00 || wb_adr_i == 8'h08 || wb_adr_i == 8'h10
        || wb_adr_i == 8'h18 || wb_adr_i == 8'h20 || wb_adr_i == 8'h28;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_after_req: assert property (req |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_dat_held: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved without ack");
    a_half_width: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (rd && !mapped |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_ctrl_width: assert property (rd && wb_adr_i == 8'h00 |=> wb_dat_o[31:4] == 28'h0000000)
        else $error("control read has stray bits");
    a_irq_masked: assert property (req && wb_we_i && wb_adr_i == 8'h28 && wb_sel_i[0]
        && !wb_dat_i[0] |=> ##1 !irq_o)
        else $error("irq high after mask");
endmodule
bind occ_top occ_top_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .slow_rc_oscillator_i(slow_rc_oscillator_i), .fast_rc_oscillator_i(fast_rc_oscillator_i),
    .slow_crystal_oscillator_i(slow_crystal_oscillator_i),
    .extended_rc_oscillator_i(extended_rc_oscillator_i), .ext_gate_i(ext_gate_i), .irq_o(irq_o));

// *** occ_osc_model.sv ***
// occ_osc_model.sv: free-running references and external gate.
// assumes: half periods are whole multiples of the 8 ns clock.
`timescale 1ns/10ps
module occ_osc_model #(
    parameter integer P0 = 96,
    parameter integer P1 = 128,
    parameter integer P2 = 208,
    parameter integer P3 = 272,
    parameter integer PE = 160
) (
    output logic o0_o, // slow rc
    output logic o1_o, // fast rc
    output logic o2_o, // slow crystal
    output logic o3_o, // extended rc
    output logic ext_o // external gate
);
    // edges land in the clock low phase, never on a sampling edge
    initial {o0_o, o1_o, o2_o, o3_o, ext_o} = 5'h00;
    always #(P0 / 2) o0_o = ~o0_o;
    always #(P1 / 2) o1_o = ~o1_o;
    always #(P2 / 2) o2_o = ~o2_o;
    always #(P3 / 2) o3_o = ~o3_o;
    always #(PE / 2) ext_o = ~ext_o;
endmodule

// *** tb_occ_top.sv ***
// tb_occ_top.sv: self-checking bench for the calibration counter.
// assumes: reference periods 12,16,26,34 and gate 20 clock cycles.
`timescale 1ns/10ps
module tb_occ_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, irq_o, osc0, osc1, osc2, osc3, gate;
    integer n_mismatch = 0;
    integer total_checks = 0;
    logic [31:0] rd, lo;
    typedef struct packed {logic g; logic [1:0] s; logic [15:0] len; logic [31:0] cnt;} occ_row_t;
    // gate select, source, window, expected count
    occ_row_t rows[7] = '{'{1'h0, 2'h0, 16'h3, 32'h24}, '{1'h0, 2'h1, 16'h3, 32'h30},
        '{1'h0, 2'h2, 16'h3, 32'h4E}, '{1'h0, 2'h3, 16'h3, 32'h66}, '{1'h1, 2'h2, 16'h4, 32'h50},
        '{1'h0, 2'h0, 16'h1, 32'hC}, '{1'h0, 2'h3, 16'h7D0, 32'h109A0}};
    always #4 clk_i = ~clk_i;
    occ_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slow_rc_oscillator_i(osc0),
        .fast_rc_oscillator_i(osc1), .slow_crystal_oscillator_i(osc2),
        .extended_rc_oscillator_i(osc3), .ext_gate_i(gate), .irq_o(irq_o));
    occ_osc_model osc (.o0_o(osc0), .o1_o(osc1), .o2_o(osc2), .o3_o(osc3), .ext_o(gate));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // counts may be one off: a reference edge lands anywhere in a clock period
    task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (^got === 1'bx || got + 32'h1 - exp > 32'h2) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        // no cycle count assumed: only the watchdog ends this wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic go(input logic g, input logic [1:0] s, input logic [15:0] len);
        wb(1'b1, 8'h08, {16'h0, len});
        wb(1'b1, 8'h00, {28'h0, g, 1'b1, s});
    endtask
    // poll the start bit; the 40000-poll bound lies past the watchdog, which ends a stuck run as a mismatch
    task automatic done();
        integer n;
        n = 0;
        do begin
            rdr(8'h00);
            n++;
        end while (rd[2] !== 1'b0 && n < 40000);
        if (rd[2] !== 1'b0) n_mismatch++;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #720000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            go(rows[i].g, rows[i].s, rows[i].len);
            done();
            rdr(8'h10);
            lo = rd;
            rdr(8'h18);
            chk_cnt({rd[15:0], lo[15:0]}, rows[i].cnt);
        end
        // result is read only and holds
        wb(1'b1, 8'h10, 32'hFFFF);
        rdr(8'h10);
        chk(rd, lo);
        rdr(8'h08);
        chk(rd, 32'h000007D0);
        // start while busy is ignored; the field still updates
        go(1'b0, 2'h0, 16'h3);
        rdr(8'h00);
        chk(rd, 32'h4);
        wb(1'b1, 8'h00, 32'h7);
        done();
        chk(rd, 32'h3);
        rdr(8'h10);
        chk_cnt(rd, 32'h24);
        // interrupt raised, cleared, then masked
        wb(1'b1, 8'h24, 32'h1);
        wb(1'b1, 8'h28, 32'h1);
        go(1'b0, 2'h1, 16'h1);
        done();
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, 8'h24, 32'h1);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, 8'h28, 32'h0);
        go(1'b0, 2'h1, 16'h1);
        done();
        rdr(8'h20);
        chk(rd, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        wb(1'b1, 8'h30, 32'hFFFF);
        rdr(8'h30);
        chk(rd, 32'h0);
        // reset in mid-run returns every register to zero
        go(1'b0, 2'h3, 16'h3);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 48; a += 8) begin
            rdr(8'(a));
            chk(rd, 32'h0);
        end
        tally_and_finish();
    end
endmodule
